// ---- logic/fpsc_pkg.sv ----
// Purpose: Shared constants and types for the flash power-state control ends.
// Assumes: One 200 MHz system clock on both ends; link pins sampled synchronously.
// Notes: Times are kept in their own unit; cycle counts are derived from them.
package fpsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WAKE_DELAY_NS = 30000;
    localparam int PUW_DELAY_NS = 1000000;
    localparam int VSL_DELAY_NS = 10000;
    localparam int DESELECT_NS = 100;
    // Waits that the host must honour round up; all of these divide evenly here.
    localparam int WAKE_DELAY_CYC = (WAKE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PUW_DELAY_CYC = (PUW_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int VSL_DELAY_CYC = (VSL_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DESELECT_CYC = (DESELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCLK_HALF_CYC = 2;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] CMD_WAKE_AND_SIGNATURE = 8'hab;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
    localparam logic [7:0] CMD_SMALL_BLOCK_CLEAR = 8'h20;
    localparam logic [7:0] CMD_BIG_BLOCK_CLEAR = 8'hd8;
    localparam logic [7:0] CMD_WHOLE_CLEAR = 8'hc7;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_ARRAY_READ = 8'h03;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [5:0] BIT_OPCODE_LAST = 6'h07;
    localparam logic [5:0] BIT_OPCODE_DONE = 6'h08;
    localparam logic [5:0] BIT_STATUS_DATA = 6'h08;
    localparam logic [5:0] BIT_SIG_DATA = 6'h20;
    localparam logic [5:0] BIT_NO_DATA = 6'h3f;

    typedef enum logic [3:0] {
        PS_OFF = 4'h1,
        PS_STANDBY = 4'h2,
        PS_DEEP = 4'h4,
        PS_WAKING = 4'h8
    } fpsc_pwr_t;

    typedef enum logic [4:0] {
        HS_WAIT = 5'h01,
        HS_IDLE = 5'h02,
        HS_LOW = 5'h04,
        HS_HIGH = 5'h08,
        HS_GUARD = 5'h10
    } fpsc_host_t;

    function automatic logic fpsc_is_write(input logic [7:0] op);
        return op == CMD_WRITE_UNLOCK || op == CMD_PAGE_WRITE || op == CMD_SMALL_BLOCK_CLEAR
            || op == CMD_BIG_BLOCK_CLEAR || op == CMD_WHOLE_CLEAR || op == CMD_STATUS_WRITE;
    endfunction : fpsc_is_write

endpackage : fpsc_pkg

// ---- logic/fpsc_link_if.sv ----
// Purpose: Chip-select framed serial link between host and flash device.
// Assumes: Only the device drives the data-out wire; nothing resolves it from miso_oe.
// Notes: No clocking block; both ends run on the system clock.
`timescale 1ns/1ps
interface fpsc_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
    modport host (output cs_n, output sclk, output mosi, input miso, input miso_oe);
endinterface : fpsc_link_if

// ---- logic/fpsc_device.sv ----
// Summary of operation
// - Early release after wake byte still reaches standby.
// - Wake from standby: standby immediately on release.
// - Wake from deep sleep: standby after wake delay.
// - Host keeps deselected for wake delay after wake.
// - Host keeps deselected until supply plus select delay.
// - Below inhibit threshold: logic held reset, silent.
// - Write-class commands ignored until write delay elapses.
// - Host sends no writes before both power-up delays.
// - Reads served after select delay, even before write delay.
// - Power-up lands in standby, never deep sleep.
// - Power-up clears the write latch.
// - Falling below inhibit threshold disables all operations.
// - Erased array reads all ones, FFh per byte.
// - Status register reads 00h as delivered.
// - Deep sleep ignores everything except wake command.
// - Wake byte, three dummy bytes, then signature on falls.
// - Deep sleep only on release after exactly eight bits.
//
// Purpose: Device end: power state, power-up write window and wake signature.
// Assumes: Link pins are synchronous to sys_clk_i; sclk is low when idle.
// Notes: Array and status contents are the delivered values; no program datapath.
`timescale 1ns/1ps
module fpsc_device
    import fpsc_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_DELAY_CYC,
    parameter int PUW_CYC = PUW_DELAY_CYC,
    parameter int VSL_CYC = VSL_DELAY_CYC,
    parameter logic [7:0] SIGNATURE = 8'h5a
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic supply_inhibit_ok_i,
    input wire logic supply_min_ok_i,
    fpsc_link_if.dev link,
    output logic standby_o,
    output logic deep_sleep_o,
    output logic write_latch_o,
    output logic write_ready_o,
    output logic write_cmd_o,
    output logic [7:0] write_cmd_code_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // The signature value above is arbitrary.
    localparam int WW = $clog2(WAKE_CYC + 1);
    localparam int PW = $clog2(PUW_CYC + 1);
    localparam int SW = $clog2(VSL_CYC + 1);
    localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_CYC - 1);
    localparam logic [PW-1:0] PUW_LAST = PW'(PUW_CYC);
    localparam logic [SW-1:0] VSL_LAST = SW'(VSL_CYC);

    typedef struct packed {
        fpsc_pwr_t state;
        logic sclk_q;
        logic cs_q;
        logic [5:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic opcode_valid;
        logic miso;
        logic miso_oe;
        logic write_latch;
        logic [7:0] status;
        logic write_pulse;
        logic [7:0] write_code;
        logic [WW-1:0] wake_cnt;
        logic [PW-1:0] puw_cnt;
        logic [SW-1:0] sel_cnt;
    } fpsc_dev_t;

    localparam fpsc_dev_t DEV_RESET = '{
        state: PS_OFF,
        sclk_q: 1'b0,
        cs_q: 1'b1,
        bit_cnt: '0,
        shreg: '0,
        opcode: '0,
        opcode_valid: 1'b0,
        miso: 1'b0,
        miso_oe: 1'b0,
        write_latch: 1'b0,
        status: STATUS_RESET,
        write_pulse: 1'b0,
        write_code: '0,
        wake_cnt: '0,
        puw_cnt: '0,
        sel_cnt: '0
    };

    fpsc_dev_t s;
    fpsc_dev_t next_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic puw_done;
    logic sel_done;
    logic [5:0] data_start;
    logic [7:0] data_byte;

    ////////////////////////////////////////////////////////////////////////////////
    assign sclk_rise = link.sclk & ~s.sclk_q;
    assign sclk_fall = ~link.sclk & s.sclk_q;
    assign cs_rise = link.cs_n & ~s.cs_q;
    assign puw_done = s.puw_cnt == PUW_LAST;
    assign sel_done = s.sel_cnt == VSL_LAST;

    // Where the data phase of the current command starts, and what it returns.
    always_comb begin
        data_start = BIT_NO_DATA;
        data_byte = ERASED_BYTE;
        if (s.opcode == CMD_WAKE_AND_SIGNATURE) begin
            data_start = BIT_SIG_DATA;
            data_byte = SIGNATURE;
        end else if (s.state == PS_DEEP) begin
            data_start = BIT_NO_DATA;
        end else if (s.opcode == CMD_STATUS_READ) begin
            data_start = BIT_STATUS_DATA;
            data_byte = {s.status[7:2], s.write_latch, 1'b0};
        end else if (s.opcode == CMD_ARRAY_READ) begin
            data_start = BIT_SIG_DATA;
            data_byte = ERASED_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.sclk_q = link.sclk;
        next_s.cs_q = link.cs_n;
        next_s.write_pulse = 1'b0;
        if (!puw_done) begin
            next_s.puw_cnt = s.puw_cnt + 1'b1;
        end
        if (!supply_min_ok_i) begin
            next_s.sel_cnt = '0;
        end else if (!sel_done) begin
            next_s.sel_cnt = s.sel_cnt + 1'b1;
        end
        case (s.state)
            PS_OFF: begin
                next_s.state = PS_STANDBY;
            end
            PS_WAKING: begin
                next_s.miso_oe = 1'b0;
                if (s.wake_cnt == WAKE_LAST) begin
                    next_s.state = PS_STANDBY;
                end else begin
                    next_s.wake_cnt = s.wake_cnt + 1'b1;
                end
            end
            PS_STANDBY, PS_DEEP: begin
                if (link.cs_n || !sel_done) begin
                    next_s.bit_cnt = '0;
                    next_s.opcode_valid = 1'b0;
                    next_s.miso_oe = 1'b0;
                    if (cs_rise && s.opcode_valid) begin
                        if (s.opcode == CMD_WAKE_AND_SIGNATURE) begin
                            if (s.state == PS_DEEP) begin
                                next_s.state = PS_WAKING;
                                next_s.wake_cnt = '0;
                            end else begin
                                next_s.state = PS_STANDBY;
                            end
                        end else if (s.state == PS_STANDBY) begin
                            if (s.opcode == CMD_DEEP_SLEEP) begin
                                if (s.bit_cnt == BIT_OPCODE_DONE) begin
                                    next_s.state = PS_DEEP;
                                end
                            end else if (s.opcode == CMD_WRITE_UNLOCK) begin
                                if (puw_done && s.bit_cnt == BIT_OPCODE_DONE) begin
                                    next_s.write_latch = 1'b1;
                                end
                            end else if (fpsc_is_write(s.opcode)) begin
                                if (puw_done && s.write_latch) begin
                                    next_s.write_pulse = 1'b1;
                                    next_s.write_code = s.opcode;
                                    next_s.write_latch = 1'b0;
                                end
                            end
                        end
                    end
                end else begin
                    if (sclk_rise) begin
                        next_s.shreg = {s.shreg[6:0], link.mosi};
                        if (s.bit_cnt == BIT_OPCODE_LAST) begin
                            next_s.opcode = {s.shreg[6:0], link.mosi};
                            next_s.opcode_valid = 1'b1;
                        end
                        // Data bytes repeat for as long as the clock keeps running.
                        if (s.opcode_valid && data_start != BIT_NO_DATA
                                && s.bit_cnt == data_start + 6'h07) begin
                            next_s.bit_cnt = data_start;
                        end else if (s.bit_cnt != BIT_NO_DATA) begin
                            next_s.bit_cnt = s.bit_cnt + 1'b1;
                        end
                    end
                    if (sclk_fall && s.opcode_valid && data_start != BIT_NO_DATA
                            && s.bit_cnt >= data_start) begin
                        next_s.miso = data_byte[~s.bit_cnt[2:0]];
                        next_s.miso_oe = 1'b1;
                    end
                end
            end
            default: begin
                next_s.state = PS_STANDBY;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Supply below the inhibit threshold acts as reset, so the link stays silent.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !supply_inhibit_ok_i) begin
            s <= DEV_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign link.miso = s.miso;
    assign link.miso_oe = s.miso_oe;
    assign standby_o = s.state == PS_STANDBY;
    assign deep_sleep_o = s.state == PS_DEEP;
    assign write_latch_o = s.write_latch;
    assign write_ready_o = puw_done;
    assign write_cmd_o = s.write_pulse;
    assign write_cmd_code_o = s.write_code;

endmodule : fpsc_device

// ---- logic/fpsc_host.sv ----
// Purpose: Host end: frames commands on the link and honours power-up and wake waits.
// Assumes: Supply status inputs are synchronous levels from the board supervisor.
// Notes: Serial clock is divided from sys_clk_i; mode 0, MSB first.
`timescale 1ns/1ps
module fpsc_host
    import fpsc_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_DELAY_CYC,
    parameter int PUW_CYC = PUW_DELAY_CYC,
    parameter int VSL_CYC = VSL_DELAY_CYC,
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic supply_inhibit_ok_i,
    input wire logic supply_min_ok_i,
    input wire logic req_i,
    input wire logic [7:0] cmd_i,
    input wire logic [2:0] dummy_bytes_i,
    input wire logic [2:0] read_bytes_i,
    fpsc_link_if.host link,
    output logic ready_o,
    output logic refused_o,
    output logic done_o,
    output logic rdata_valid_o,
    output logic [7:0] rdata_o
);

    ////////////////////////////////////////////////////////////////////////////////
    localparam int GW = $clog2(WAKE_CYC + DESELECT_CYC + 1);
    localparam int PW = $clog2(PUW_CYC + 1);
    localparam int SW = $clog2(VSL_CYC + 1);
    localparam int DW = $clog2(HALF_CYC + 1);
    localparam logic [GW-1:0] WAKE_LAST = GW'(WAKE_CYC - 1);
    localparam logic [GW-1:0] DESEL_LAST = GW'(DESELECT_CYC - 1);
    localparam logic [PW-1:0] PUW_LAST = PW'(PUW_CYC);
    localparam logic [SW-1:0] VSL_LAST = SW'(VSL_CYC);
    localparam logic [DW-1:0] HALF_LAST = DW'(HALF_CYC - 1);

    typedef struct packed {
        fpsc_host_t state;
        logic cs_n;
        logic sclk;
        logic mosi;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [6:0] bit_cnt;
        logic [6:0] last_bit;
        logic [6:0] rd_start;
        logic was_wake;
        logic [DW-1:0] div_cnt;
        logic [GW-1:0] guard_cnt;
        logic [PW-1:0] puw_cnt;
        logic [SW-1:0] sel_cnt;
        logic ready;
        logic refused;
        logic done;
        logic rdata_valid;
        logic [7:0] rdata;
    } fpsc_host_st_t;

    fpsc_host_st_t s;
    fpsc_host_st_t next_s;
    logic puw_done;
    logic sel_done;

    assign puw_done = s.puw_cnt == PUW_LAST;
    assign sel_done = s.sel_cnt == VSL_LAST;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.refused = 1'b0;
        next_s.done = 1'b0;
        next_s.rdata_valid = 1'b0;
        if (!supply_inhibit_ok_i) begin
            next_s.puw_cnt = '0;
        end else if (!puw_done) begin
            next_s.puw_cnt = s.puw_cnt + 1'b1;
        end
        if (!supply_min_ok_i) begin
            next_s.sel_cnt = '0;
        end else if (!sel_done) begin
            next_s.sel_cnt = s.sel_cnt + 1'b1;
        end
        case (s.state)
            HS_WAIT: begin
                if (sel_done) begin
                    next_s.state = HS_IDLE;
                end
            end
            HS_IDLE: begin
                if (req_i) begin
                    if (fpsc_is_write(cmd_i) && !(puw_done && sel_done)) begin
                        next_s.refused = 1'b1;
                    end else begin
                        next_s.state = HS_LOW;
                        next_s.cs_n = 1'b0;
                        next_s.sclk = 1'b0;
                        next_s.tx = cmd_i;
                        next_s.mosi = cmd_i[7];
                        next_s.bit_cnt = '0;
                        next_s.div_cnt = '0;
                        next_s.was_wake = cmd_i == CMD_WAKE_AND_SIGNATURE;
                        // Dummy bytes after the opcode go out as zeros.
                        next_s.last_bit = {1'b0, 3'h1 + dummy_bytes_i + read_bytes_i, 3'h0} - 1'b1;
                        next_s.rd_start = {1'b0, 3'h1 + dummy_bytes_i, 3'h0};
                    end
                end
            end
            HS_LOW: begin
                next_s.div_cnt = s.div_cnt + 1'b1;
                if (s.div_cnt == HALF_LAST) begin
                    next_s.state = HS_HIGH;
                    next_s.div_cnt = '0;
                    next_s.sclk = 1'b1;
                    next_s.rx = {s.rx[6:0], link.miso};
                    if (s.bit_cnt >= s.rd_start && s.bit_cnt[2:0] == 3'h7) begin
                        next_s.rdata = {s.rx[6:0], link.miso};
                        next_s.rdata_valid = 1'b1;
                    end
                end
            end
            HS_HIGH: begin
                next_s.div_cnt = s.div_cnt + 1'b1;
                if (s.div_cnt == HALF_LAST) begin
                    next_s.div_cnt = '0;
                    next_s.sclk = 1'b0;
                    if (s.bit_cnt == s.last_bit) begin
                        next_s.state = HS_GUARD;
                        next_s.cs_n = 1'b1;
                        next_s.mosi = 1'b0;
                        next_s.guard_cnt = '0;
                    end else begin
                        next_s.state = HS_LOW;
                        next_s.bit_cnt = s.bit_cnt + 1'b1;
                        next_s.tx = {s.tx[6:0], 1'b0};
                        next_s.mosi = s.tx[6];
                    end
                end
            end
            HS_GUARD: begin
                next_s.guard_cnt = s.guard_cnt + 1'b1;
                // The device may have been asleep, so every wake waits the full delay.
                if (s.guard_cnt == (s.was_wake ? WAKE_LAST : DESEL_LAST)) begin
                    next_s.state = HS_IDLE;
                    next_s.done = 1'b1;
                end
            end
            default: begin
                next_s.state = HS_WAIT;
            end
        endcase
        if (!supply_min_ok_i) begin
            next_s.state = HS_WAIT;
            next_s.cs_n = 1'b1;
            next_s.sclk = 1'b0;
            next_s.mosi = 1'b0;
        end
        next_s.ready = next_s.state == HS_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s <= '{state: HS_WAIT, cs_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign link.cs_n = s.cs_n;
    assign link.sclk = s.sclk;
    assign link.mosi = s.mosi;
    assign ready_o = s.ready;
    assign refused_o = s.refused;
    assign done_o = s.done;
    assign rdata_valid_o = s.rdata_valid;
    assign rdata_o = s.rdata;

endmodule : fpsc_host

// ---- verif/fpsc_asserts.sv ----
// Purpose: Checks on the link and device power state.
// Assumes: One clock; synchronous active-low reset.
// Notes: Long waits use counters, not repetitions.
`timescale 1ns/1ps
module fpsc_asserts #(
    parameter int WAKE_CYC = 20,
    parameter int PUW_CYC = 300
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic supply_inhibit_ok_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic miso_oe,
    input wire logic standby_o,
    input wire logic deep_sleep_o,
    input wire logic write_latch_o,
    input wire logic write_ready_o,
    input wire logic write_cmd_o
);
    localparam int WAKE_HI = WAKE_CYC + 4;
    logic sclk_q = 1'b0;
    logic waking = 1'b0;
    logic [7:0] bits = 8'h00;
    logic [7:0] last_bits = 8'h00;
    int puw_cnt = 0;
    int wake_cnt = 0;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    // Waking is kept apart from power-up, which also raises standby.
    always_ff @(posedge sys_clk_i) begin
        sclk_q <= sclk;
        bits <= cs_n ? 8'h00 : ((sclk && !sclk_q) ? bits + 8'h01 : bits);
        if (cs_n && bits != 8'h00) last_bits <= bits;
        puw_cnt <= (!rst_n_i || !supply_inhibit_ok_i) ? 0 : puw_cnt + 1;
        wake_cnt <= $fell(deep_sleep_o) ? 0 : wake_cnt + 1;
        if ($fell(deep_sleep_o) && supply_inhibit_ok_i) waking <= 1'b1;
        else if (standby_o || !supply_inhibit_ok_i) waking <= 1'b0;
    end
    sequence s_powered;
        !deep_sleep_o ##[1:3] standby_o;
    endsequence
    sequence s_woken;
        !standby_o ##[1:WAKE_HI] standby_o;
    endsequence
    ////////////////////////////////////////////////////////////
    AST_SILENT_BELOW_INHIBIT:
        assert property (!supply_inhibit_ok_i |=> !standby_o && !deep_sleep_o && !miso_oe
            && !write_latch_o) else $error("active when off");
    AST_POWER_DOWN_NO_WRITE:
        assert property ($fell(supply_inhibit_ok_i) |=> !write_ready_o [*2])
        else $error("write ready when off");
    AST_POWER_UP_STANDBY:
        assert property ($rose(supply_inhibit_ok_i) |-> s_powered)
        else $error("no standby");
    AST_LATCH_NEEDS_DELAY:
        assert property ($rose(write_latch_o) || write_cmd_o |-> write_ready_o)
        else $error("write before delay");
    AST_WRITE_DELAY_LENGTH:
        assert property ($rose(write_ready_o) |-> puw_cnt >= PUW_CYC - 2)
        else $error("write delay short");
    AST_WAKE_BOUND:
        assert property ($fell(deep_sleep_o) && supply_inhibit_ok_i |-> s_woken)
        else $error("wake too long");
    AST_WAKE_LENGTH:
        assert property ($rose(standby_o) && waking |-> wake_cnt >= WAKE_CYC - 2)
        else $error("wake too short");
    AST_STANDBY_KEPT:
        assert property (standby_o && supply_inhibit_ok_i |=> standby_o or ##[0:1] deep_sleep_o)
        else $error("standby left");
    AST_DEEP_EIGHT_BITS:
        assert property ($rose(deep_sleep_o) |-> last_bits == 8'h08)
        else $error("deep sleep bit count");
endmodule : fpsc_asserts

// ---- verif/flash_power_state_control_test.sv ----
// Purpose: Bench for host and device ends.
// Assumes: Short, equal delays on both ends.
// Notes: Only the device drives miso.
`timescale 1ns/1ps
module flash_power_state_control_test
    import fpsc_pkg::*;
;
    localparam int WAKE = 20;
    localparam int PUW = 300;
    localparam int VSL = 10;
    localparam logic [7:0] SIG = 8'h5a; // Arbitrary value.
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic inh_ok = 1'b0;
    logic min_ok = 1'b0;
    logic req_i = 1'b0;
    logic [7:0] cmd_i = 8'h00;
    logic [2:0] dummy_bytes_i = 3'h0;
    logic [2:0] read_bytes_i = 3'h0;
    logic ready, refused, done, rd_valid, standby, deep, latch, wready, wcmd, got_ref;
    logic [7:0] rdata, wcode, last_rd;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    fpsc_link_if link_bus ();
    fpsc_device #(.WAKE_CYC(WAKE), .PUW_CYC(PUW), .VSL_CYC(VSL), .SIGNATURE(SIG)) u_fpsc_device (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_inhibit_ok_i(inh_ok),
        .supply_min_ok_i(min_ok), .link(link_bus), .standby_o(standby), .deep_sleep_o(deep),
        .write_latch_o(latch), .write_ready_o(wready), .write_cmd_o(wcmd),
        .write_cmd_code_o(wcode));
    fpsc_host #(.WAKE_CYC(WAKE), .PUW_CYC(PUW), .VSL_CYC(VSL), .HALF_CYC(2)) u_fpsc_host (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_inhibit_ok_i(inh_ok),
        .supply_min_ok_i(min_ok), .req_i(req_i), .cmd_i(cmd_i), .dummy_bytes_i(dummy_bytes_i),
        .read_bytes_i(read_bytes_i), .link(link_bus), .ready_o(ready), .refused_o(refused),
        .done_o(done), .rdata_valid_o(rd_valid), .rdata_o(rdata));
    fpsc_asserts #(.WAKE_CYC(WAKE), .PUW_CYC(PUW)) u_fpsc_asserts (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_inhibit_ok_i(inh_ok),
        .cs_n(link_bus.cs_n), .sclk(link_bus.sclk), .miso_oe(link_bus.miso_oe),
        .standby_o(standby), .deep_sleep_o(deep), .write_latch_o(latch),
        .write_ready_o(wready), .write_cmd_o(wcmd));
    ////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic xfer(input logic [7:0] c, input logic [2:0] d, input logic [2:0] r);
        while (ready !== 1'b1) tick(1);
        cmd_i = c;
        dummy_bytes_i = d;
        read_bytes_i = r;
        req_i = 1'b1;
        last_rd = 8'hxx;
        got_ref = 1'b0;
        tick(1);
        req_i = 1'b0;
        while (done !== 1'b1 && got_ref !== 1'b1) begin
            if (rd_valid === 1'b1) last_rd = rdata;
            if (refused === 1'b1) got_ref = 1'b1;
            tick(1);
        end
    endtask : xfer
    task automatic wake_low(output int lo);
        lo = 0;
        fork
            xfer(CMD_WAKE_AND_SIGNATURE, 3'd0, 3'd0);
            begin
                @(posedge link_bus.cs_n);
                tick(1);
                repeat (WAKE + 10) begin
                    if (standby !== 1'b1) lo++;
                    tick(1);
                end
            end
        join
    endtask : wake_low
    ////////////////////////////////////////////////////////////
    task automatic t_power_up();
        tick(3);
        check("standby", 8'h01, 8'(standby));
        check("deep", 8'h00, 8'(deep));
        check("latch", 8'h00, 8'(latch));
        check("cs_n", 8'h01, 8'(link_bus.cs_n));
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_early();
        xfer(CMD_WRITE_UNLOCK, 3'd0, 3'd0);
        check("refused", 8'h01, 8'(got_ref));
        check("early latch", 8'h00, 8'(latch));
        xfer(CMD_STATUS_READ, 3'd0, 3'd1);
        check("status", STATUS_RESET, last_rd);
        check("wready", 8'h00, 8'(wready));
        xfer(CMD_ARRAY_READ, 3'd3, 3'd1);
        check("array", ERASED_BYTE, last_rd);
        $display("test early done");
    endtask : t_early
    task automatic t_write();
        while (wready !== 1'b1) tick(1);
        xfer(CMD_WRITE_UNLOCK, 3'd0, 3'd0);
        check("latch set", 8'h01, 8'(latch));
        xfer(CMD_STATUS_READ, 3'd0, 3'd1);
        check("status latch", 8'h02, last_rd);
        xfer(CMD_SMALL_BLOCK_CLEAR, 3'd3, 3'd0);
        check("latch clear", 8'h00, 8'(latch));
        check("code", CMD_SMALL_BLOCK_CLEAR, wcode);
        $display("test write done");
    endtask : t_write
    task automatic t_sleep();
        int lo;
        xfer(CMD_DEEP_SLEEP, 3'd1, 3'd0);
        check("deep 16", 8'h00, 8'(deep));
        xfer(CMD_DEEP_SLEEP, 3'd0, 3'd0);
        check("deep 8", 8'h01, 8'(deep));
        xfer(CMD_STATUS_READ, 3'd0, 3'd1);
        check("deep read", 8'h01, 8'(deep));
        xfer(CMD_WAKE_AND_SIGNATURE, 3'd3, 3'd1);
        tick(3);
        check("sig", SIG, last_rd);
        check("woken", 8'h01, 8'(standby));
        xfer(CMD_DEEP_SLEEP, 3'd0, 3'd0);
        wake_low(lo);
        check("wake length", 8'h01, 8'(lo >= WAKE && lo <= WAKE + 3));
        wake_low(lo);
        check("standby wake", 8'h00, 8'(lo));
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_power_down();
        xfer(CMD_WRITE_UNLOCK, 3'd0, 3'd0);
        xfer(CMD_DEEP_SLEEP, 3'd0, 3'd0);
        inh_ok = 1'b0;
        min_ok = 1'b0;
        tick(3);
        check("standby off", 8'h00, 8'(standby));
        check("oe off", 8'h00, 8'(link_bus.miso_oe));
        inh_ok = 1'b1;
        min_ok = 1'b1;
        tick(3);
        check("deep on", 8'h00, 8'(deep));
        check("latch on", 8'h00, 8'(latch));
        $display("test power_down done");
    endtask : t_power_down
    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        tick(5);
        rst_n_i = 1'b1;
        inh_ok = 1'b1;
        min_ok = 1'b1;
        t_power_up();
        t_early();
        t_write();
        t_sleep();
        t_power_down();
        end_of_test();
    end
endmodule : flash_power_state_control_test
